// ### core/pmio_dwell.sv
// Dwell timer: holds its output for a number of time-base ticks, may be cut short.
`timescale 1ns/10ps
`include "pmio_regs.svh"
module pmio_dwell (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Control.
  input wire logic tick,
  input wire logic start,
  input wire logic abort,
  input wire logic [15:0] dwell,
  // Result.
  output logic on,
  output logic done
);
  logic [15:0] cnt;

  // The timer ends on its last tick, on an abort, or at once for a zero dwell.
  assign done = (start && dwell == `PMIO_DWELL_RST) ||
                (on && !start && (abort || (tick && cnt == `PMIO_CNT_LAST)));

  // Count down the dwell while the output is on.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= `PMIO_DWELL_RST;
      on <= 1'b0;
    end
    else if (start)
    begin
      cnt <= dwell;
      on <= (dwell != `PMIO_DWELL_RST);
    end
    else if (on && abort)
    begin
      cnt <= `PMIO_DWELL_RST;
      on <= 1'b0;
    end
    else if (on && tick)
    begin
      cnt <= cnt - `PMIO_CNT_LAST;
      on <= (cnt != `PMIO_CNT_LAST);
    end
  end
endmodule // pmio_dwell

// ### core/pmio_pkg.sv
// Types shared by the press motion sequencer files.
package pmio_pkg;

  // Operating modes of the motion outputs.
  typedef enum logic [2:0] {
    PMIO_HALT,
    PMIO_JOG_F,
    PMIO_JOG_R,
    PMIO_RUN_F,
    PMIO_RUN_S
  } pmio_mode_e;

  // Switch and photo-cell inputs, one bit each except the two-bit down and up limit switches.
  typedef struct packed {
    logic jog_fwd;
    logic jog_rev;
    logic run;
    logic man_stack;
    logic print_det;
    logic hole_det;
    logic [1:0] down_done;
    logic [1:0] up_done;
  } pmio_sw_s;

  // Motion output group.
  typedef struct packed {
    logic fast;
    logic slow;
    logic rev;
    logic fwd;
    logic run;
  } pmio_motion_s;

endpackage

// ### core/pmio_regs.svh
// Register map, field positions, reset values and timing constants of the press motion sequencer.
`ifndef PMIO_REGS_SVH
`define PMIO_REGS_SVH

// Byte addresses of the APB registers.
`define PMIO_A_CTRL 12'h000
`define PMIO_A_CMD 12'h004
`define PMIO_A_DDOWN 12'h008
`define PMIO_A_DUP 12'h00C
`define PMIO_A_DBOOST 12'h010
`define PMIO_A_DITEM 12'h014
`define PMIO_A_DSTACK 12'h018
`define PMIO_A_STARGET 12'h01C
`define PMIO_A_STATUS 12'h020
`define PMIO_A_HOLEREF 12'h024

// Control register fields.
`define PMIO_C_SLOWHALT 0
`define PMIO_C_JOBVALID 1
`define PMIO_C_ERRBLOCK 2
`define PMIO_C_FASTSEL 3
`define PMIO_C_PRINTEN 4
`define PMIO_C_HOLEEN 5
`define PMIO_CTRL_W 6
`define PMIO_CTRL_RST 6'h00

// Command register fields, write only, self clearing.
`define PMIO_K_CUT0 0
`define PMIO_K_CUT1 1
`define PMIO_K_ITEM 2

// Status register fields; message request and hole seen are write one to clear.
`define PMIO_S_MODE 2:0
`define PMIO_S_RUN 3
`define PMIO_S_MSGREQ 8
`define PMIO_S_HOLESEEN 9
`define PMIO_S_COUNT 31:16

// Dwell registers are tick counts; reset values.
`define PMIO_DWELL_RST 16'h0000
`define PMIO_TARGET_RST 16'h0000
`define PMIO_PRINT_TICKS 16'h000A
`define PMIO_CNT_LAST 16'h0001

// Dwell time base: clock period and tick period in nanoseconds.
`define PMIO_CLK_NS 5
`define PMIO_TICK_NS 1000000

`endif

// ### core/pmio_seq.sv
// Press motion I/O sequencer with APB registers.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "pmio_regs.svh"
module pmio_seq #(
  parameter int TICK_CYCLES = `PMIO_TICK_NS / `PMIO_CLK_NS
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RSTN,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Machine switches and photo-cells, asynchronous.
  input wire logic JOG_FWD,
  input wire logic JOG_REV,
  input wire logic RUN_IN,
  input wire logic MAN_STACK,
  input wire logic PRINT_DET,
  input wire logic HOLE_DET,
  input wire logic [1:0] DOWN_DONE,
  input wire logic [1:0] UP_DONE,
  // Material position from the encoder logic, same clock.
  input wire logic [31:0] MAT_POS,
  // Motion outputs.
  output logic FAST,
  output logic SLOW,
  output logic REV,
  output logic FWD,
  output logic RUN,
  // Press outputs; index 0 is the shear.
  output logic [1:0] PRESS_DOWN,
  output logic [1:0] PRESS_UP,
  output logic [1:0] BOOST,
  // Pulsed outputs.
  output logic ITEM_DONE,
  output logic STACKER,
  output logic PRINT_TRIG
);
  pmio_pkg::pmio_sw_s sw_raw, sw_meta, sw, sw_prev, sw_rise;
  pmio_pkg::pmio_mode_e mode;
  pmio_pkg::pmio_motion_s motion, next_motion;
  logic [`PMIO_CTRL_W-1:0] ctrl;
  logic [15:0] d_down, d_up, d_boost, d_item, d_stack, s_target, s_count;
  logic [31:0] hole_ref, rd_word;
  logic [31:0] tick_cnt;
  logic tick, run_on, next_run_on, msg_req, hole_seen;
  logic wr_en, addr_ok, item_go, stack_go, print_go, hole_go, count_hit;
  logic [1:0] cut_go, down_end, up_end;
  logic [1:0] down_on, up_on, boost_on;
  logic item_on, stack_on, print_on;

  // Two flip-flop synchroniser, then a previous copy for edge detection.
  assign sw_raw = {JOG_FWD, JOG_REV, RUN_IN, MAN_STACK, PRINT_DET, HOLE_DET, DOWN_DONE, UP_DONE};
  assign sw_rise = sw & ~sw_prev;
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sw_meta <= '0;
      sw <= '0;
      sw_prev <= '0;
    end
    else
    begin
      sw_meta <= sw_raw;
      sw <= sw_meta;
      sw_prev <= sw;
    end
  end

  // Time-base divider giving a one-cycle tick.
  assign tick = (tick_cnt == TICK_CYCLES - 1);
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      tick_cnt <= '0;
    else
      tick_cnt <= tick ? '0 : tick_cnt + 32'h00000001;
  end

  // Run mode enters on a run press with a valid job and no error block, and leaves as soon as run drops.
  assign next_run_on = !sw.run ? 1'b0 :
                       (sw_rise.run && ctrl[`PMIO_C_JOBVALID] && !ctrl[`PMIO_C_ERRBLOCK]) ? 1'b1 :
                       run_on;

  // Mode selection; jog requests only count outside run and only while held.
  assign mode = run_on ? (ctrl[`PMIO_C_FASTSEL] ? pmio_pkg::PMIO_RUN_F : pmio_pkg::PMIO_RUN_S) :
                sw.jog_fwd ? pmio_pkg::PMIO_JOG_F :
                sw.jog_rev ? pmio_pkg::PMIO_JOG_R : pmio_pkg::PMIO_HALT;

  // Motion output table per mode.
  always_comb
  begin
    next_motion = '0;
    unique case (mode)
      pmio_pkg::PMIO_HALT: next_motion.slow = ctrl[`PMIO_C_SLOWHALT];
      pmio_pkg::PMIO_JOG_F: next_motion = '{fast: 1'b0, slow: 1'b1, rev: 1'b0, fwd: 1'b1, run: 1'b0};
      pmio_pkg::PMIO_JOG_R: next_motion = '{fast: 1'b0, slow: 1'b1, rev: 1'b1, fwd: 1'b0, run: 1'b0};
      pmio_pkg::PMIO_RUN_F: next_motion = '{fast: 1'b1, slow: 1'b0, rev: 1'b0, fwd: 1'b1, run: 1'b1};
      pmio_pkg::PMIO_RUN_S: next_motion = '{fast: 1'b0, slow: 1'b1, rev: 1'b0, fwd: 1'b1, run: 1'b1};
      default: next_motion = '0;
    endcase
  end

  // Registered run state and motion outputs.
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      run_on <= 1'b0;
      motion <= '0;
    end
    else
    begin
      run_on <= next_run_on;
      motion <= next_motion;
    end
  end
  assign {FAST, SLOW, REV, FWD, RUN} = motion;

  // APB decode; the answer is ready in the first access cycle.
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE;
  assign addr_ok = (PADDR <= `PMIO_A_HOLEREF) && (PADDR[1:0] == 2'h0);
  always_comb
  begin
    rd_word = '0;
    unique case (PADDR)
      `PMIO_A_CTRL: rd_word[`PMIO_CTRL_W-1:0] = ctrl;
      `PMIO_A_DDOWN: rd_word[15:0] = d_down;
      `PMIO_A_DUP: rd_word[15:0] = d_up;
      `PMIO_A_DBOOST: rd_word[15:0] = d_boost;
      `PMIO_A_DITEM: rd_word[15:0] = d_item;
      `PMIO_A_DSTACK: rd_word[15:0] = d_stack;
      `PMIO_A_STARGET: rd_word[15:0] = s_target;
      `PMIO_A_STATUS:
      begin
        rd_word[`PMIO_S_MODE] = mode;
        rd_word[`PMIO_S_RUN] = run_on;
        rd_word[`PMIO_S_MSGREQ] = msg_req;
        rd_word[`PMIO_S_HOLESEEN] = hole_seen;
        rd_word[`PMIO_S_COUNT] = s_count;
      end
      `PMIO_A_HOLEREF: rd_word = hole_ref;
      default: rd_word = '0;
    endcase
  end

  // Bus answer registers and software-written registers.
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      PREADY <= 1'b0;
      PRDATA <= '0;
      PSLVERR <= 1'b0;
      ctrl <= `PMIO_CTRL_RST;
      {d_down, d_up, d_boost} <= {3{`PMIO_DWELL_RST}};
      {d_item, d_stack} <= {2{`PMIO_DWELL_RST}};
      s_target <= `PMIO_TARGET_RST;
    end
    else
    begin
      PREADY <= PSEL && !PENABLE;
      PRDATA <= (PSEL && !PENABLE && !PWRITE) ? rd_word : '0;
      PSLVERR <= PSEL && !PENABLE && !addr_ok;
      if (wr_en)
      begin
        unique case (PADDR)
          `PMIO_A_CTRL: ctrl <= PWDATA[`PMIO_CTRL_W-1:0];
          `PMIO_A_DDOWN: d_down <= PWDATA[15:0];
          `PMIO_A_DUP: d_up <= PWDATA[15:0];
          `PMIO_A_DBOOST: d_boost <= PWDATA[15:0];
          `PMIO_A_DITEM: d_item <= PWDATA[15:0];
          `PMIO_A_DSTACK: d_stack <= PWDATA[15:0];
          `PMIO_A_STARGET: s_target <= PWDATA[15:0];
          default: ;
        endcase
      end
    end
  end

  // Event decode for cuts, items, stacker, print and hole.
  assign cut_go = (wr_en && PADDR == `PMIO_A_CMD) ?
                  (PWDATA[`PMIO_K_CUT1:`PMIO_K_CUT0] & ~(down_on | up_on)) : 2'h0;
  assign item_go = wr_en && PADDR == `PMIO_A_CMD && PWDATA[`PMIO_K_ITEM] && run_on;
  assign count_hit = cut_go[0] && s_target != `PMIO_TARGET_RST &&
                     s_count + `PMIO_CNT_LAST >= s_target;
  assign stack_go = sw_rise.man_stack || count_hit;
  assign print_go = sw_rise.print_det && ctrl[`PMIO_C_PRINTEN];
  assign hole_go = sw_rise.hole_det && ctrl[`PMIO_C_HOLEEN];

  // Shear and press cycles: down with boost, then up.
  for (genvar g = 0; g < 2; g++)
  begin : g_tool
    pmio_dwell u_down (.clk(REF_CLK), .rstn(RSTN), .tick(tick), .start(cut_go[g]),
      .abort(sw.down_done[g]), .dwell(d_down), .on(down_on[g]), .done(down_end[g]));
    pmio_dwell u_up (.clk(REF_CLK), .rstn(RSTN), .tick(tick), .start(down_end[g]),
      .abort(sw.up_done[g]), .dwell(d_up), .on(up_on[g]), .done(up_end[g]));
    pmio_dwell u_boost (.clk(REF_CLK), .rstn(RSTN), .tick(tick), .start(cut_go[g]),
      .abort(1'b0), .dwell(d_boost), .on(boost_on[g]), .done());
  end
  assign PRESS_DOWN = down_on;
  assign PRESS_UP = up_on;
  assign BOOST = boost_on;

  // Item complete, stacker and print trigger pulses.
  pmio_dwell u_item (.clk(REF_CLK), .rstn(RSTN), .tick(tick), .start(item_go), .abort(1'b0),
    .dwell(d_item), .on(item_on), .done());
  pmio_dwell u_stack (.clk(REF_CLK), .rstn(RSTN), .tick(tick), .start(stack_go), .abort(1'b0),
    .dwell(d_stack), .on(stack_on), .done());
  pmio_dwell u_print (.clk(REF_CLK), .rstn(RSTN), .tick(tick), .start(print_go), .abort(1'b0),
    .dwell(`PMIO_PRINT_TICKS), .on(print_on), .done());
  assign ITEM_DONE = item_on;
  assign STACKER = stack_on;
  assign PRINT_TRIG = print_on;

  // Part counter, message request, hole reference; a new print or hole event beats a clear, a stacker clear beats a count.
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      s_count <= `PMIO_TARGET_RST;
      msg_req <= 1'b0;
      hole_seen <= 1'b0;
      hole_ref <= '0;
    end
    else
    begin
      if (stack_go)
        s_count <= `PMIO_TARGET_RST;
      else if (cut_go[0])
        s_count <= s_count + `PMIO_CNT_LAST;
      if (print_go)
        msg_req <= 1'b1;
      else if (wr_en && PADDR == `PMIO_A_STATUS && PWDATA[`PMIO_S_MSGREQ])
        msg_req <= 1'b0;
      if (hole_go)
        hole_seen <= 1'b1;
      else if (wr_en && PADDR == `PMIO_A_STATUS && PWDATA[`PMIO_S_HOLESEEN])
        hole_seen <= 1'b0;
      if (hole_go)
        hole_ref <= MAT_POS;
    end
  end

  // Checks on the sequencing.
  a_down_bottom_stop: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    down_on[1] && sw.down_done[1] && !cut_go[1] |=> !down_on[1])
    else $error("Press down stayed on after bottom input.");
  a_up_top_stop: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    up_on[1] && sw.up_done[1] && !down_end[1] |=> !up_on[1])
    else $error("Up output stayed on after top input.");
  a_up_after_down: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    down_on[0] ##1 !down_on[0] && d_up != `PMIO_DWELL_RST |-> up_on[0])
    else $error("Up stroke did not follow down stroke.");
  a_shear_full_dwell: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    down_on[0] && !tick && !sw.down_done[0] |=> down_on[0])
    else $error("Shear down ended without tick or bottom input.");
  a_jog_fwd_table: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    mode == pmio_pkg::PMIO_JOG_F |=> SLOW && FWD && !FAST && !REV && !RUN)
    else $error("Jog forward outputs wrong.");
  a_run_fast_table: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    mode == pmio_pkg::PMIO_RUN_F |=> FAST && FWD && RUN && !SLOW && !REV)
    else $error("Run fast outputs wrong.");
  a_slow_halted: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    mode == pmio_pkg::PMIO_HALT |=> SLOW == $past(ctrl[`PMIO_C_SLOWHALT]))
    else $error("Slow output wrong while halted.");
  a_run_entry_ok: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    !run_on ##1 run_on |-> $past(ctrl[`PMIO_C_JOBVALID]) && !$past(ctrl[`PMIO_C_ERRBLOCK]))
    else $error("Run entered without valid job.");
  a_jog_in_run: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    run_on |-> ##1 !REV)
    else $error("Reverse jog acted in run mode.");
  a_run_drop: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    !sw.run |=> !run_on ##1 !RUN)
    else $error("Run mode kept after run input dropped.");
  a_item_in_run: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    $rose(item_on) |-> $past(run_on))
    else $error("Item complete pulsed outside run.");
  a_stack_manual: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    sw_rise.man_stack && d_stack != `PMIO_DWELL_RST |=> STACKER && s_count == `PMIO_TARGET_RST)
    else $error("Manual stacker did not pulse and clear.");
  a_print_trigger: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    print_go |=> PRINT_TRIG && msg_req)
    else $error("Print detect did not trigger.");
  a_hole_capture: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    hole_go |=> hole_ref == $past(MAT_POS))
    else $error("Hole reference not captured.");
  a_boost_start: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    cut_go[0] && d_boost != `PMIO_DWELL_RST |=> BOOST[0])
    else $error("Boost did not start with the cut.");
endmodule // pmio_seq

// ### tb/pmio_machine.sv
// Behavioural press tooling: bottom and top limit switches of the two tools.
`timescale 1ns/10ps
module pmio_machine (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Tool solenoids from the sequencer.
  input wire logic [1:0] press_down,
  input wire logic [1:0] press_up,
  // Which switches are fitted, and stroke travel time in cycles.
  input wire logic [1:0] bot_fit,
  input wire logic [1:0] top_fit,
  input wire logic [7:0] travel,
  // Limit switches.
  output logic [1:0] down_done,
  output logic [1:0] up_done
);
  logic [7:0] dcnt [2];
  logic [7:0] ucnt [2];
  // A fitted switch closes once a stroke has run its travel time; unfitted ones stay low.
  always_ff @(posedge clk or negedge rstn)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (!rstn)
      begin
        dcnt[i] <= 8'h00;
        ucnt[i] <= 8'h00;
        down_done[i] <= 1'b0;
        up_done[i] <= 1'b0;
      end
      else
      begin
        dcnt[i] <= press_down[i] ? dcnt[i] + 8'h01 : 8'h00;
        ucnt[i] <= press_up[i] ? ucnt[i] + 8'h01 : 8'h00;
        down_done[i] <= bot_fit[i] && press_down[i] && dcnt[i] >= travel;
        up_done[i] <= top_fit[i] && press_up[i] && ucnt[i] >= travel;
      end
    end
  end
endmodule // pmio_machine

// ### tb/press_motion_io_sequencer_tb_top.sv
// Self-checking bench of the press motion sequencer with its tooling model.
`timescale 1ns/10ps
`include "pmio_regs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module press_motion_io_sequencer_tb_top;
  localparam int T = 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, mat_pos = 32'h0;
  logic pready, pslverr, fast, slow, rev, fwd, run, item_done, stacker, print_trig;
  logic jog_f = 1'b0, jog_r = 1'b0, run_in = 1'b0, man_st = 1'b0, print_det = 1'b0;
  logic hole_det = 1'b0;
  logic [1:0] down_done, up_done, press_down, press_up, boost;
  logic [1:0] bot_fit = 2'b00, top_fit = 2'b00;
  int miscompares = 0;
  int tests_run = 0;
  wire [8:0] pv = {print_trig, stacker, item_done, boost, press_up, press_down};
  // Clock at 200 MHz.
  always #2.5 clk = ~clk;
  // Device under test and the tooling on its far side.
  pmio_seq #(.TICK_CYCLES(T)) uut (.REF_CLK(clk), .RSTN(rstn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .JOG_FWD(jog_f), .JOG_REV(jog_r), .RUN_IN(run_in),
    .MAN_STACK(man_st), .PRINT_DET(print_det), .HOLE_DET(hole_det), .DOWN_DONE(down_done),
    .UP_DONE(up_done), .MAT_POS(mat_pos), .FAST(fast), .SLOW(slow), .REV(rev), .FWD(fwd),
    .RUN(run), .PRESS_DOWN(press_down), .PRESS_UP(press_up), .BOOST(boost),
    .ITEM_DONE(item_done), .STACKER(stacker), .PRINT_TRIG(print_trig));
  pmio_machine mach (.clk(clk), .rstn(rstn), .press_down(press_down), .press_up(press_up),
    .bot_fit(bot_fit), .top_fit(top_fit), .travel(8'h04), .down_done(down_done),
    .up_done(up_done));
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One APB transfer; the request stands until PREADY is seen at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50)
    begin
      miscompares++;
      end_sim();
    end
  endtask
  // Register write without a returned value.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  // Waits for a pulse on output i and returns its width in cycles, or -1 if none came.
  task automatic pw(input int i, input int lim, output int w);
    int n;
    w = -1;
    @(negedge clk);
    for (n = 0; n < lim && pv[i] !== 1'b1; n++)
      @(negedge clk);
    for (n = 0; n < 5000 && pv[i] === 1'b1; n++)
      @(negedge clk);
    if (n > 0)
      w = n;
  endtask
  // Lets the switch path settle and compares the motion group.
  task automatic mot(input logic [4:0] x);
    repeat (8) @(negedge clk);
    `CHK({fast, slow, rev, fwd, run}, x)
  endtask
  // Mode table, slow while halted, run entry conditions, jog lockout and run exit.
  task automatic t_motion();
    logic [31:0] q;
    logic e;
    apb(1'b0, 12'h040, 32'h0, q, e);
    `CHK({e, q}, {1'b1, 32'h0})
    mot(5'b00000);
    wr(`PMIO_A_CTRL, 32'h1);
    mot(5'b01000);
    @(posedge clk) jog_f <= 1'b1;
    mot(5'b01010);
    @(posedge clk) jog_f <= 1'b0;
    mot(5'b01000);
    @(posedge clk) jog_r <= 1'b1;
    mot(5'b01100);
    @(posedge clk) jog_r <= 1'b0;
    @(posedge clk) run_in <= 1'b1;
    mot(5'b01000);
    @(posedge clk) run_in <= 1'b0;
    wr(`PMIO_A_CTRL, 32'hE);
    @(posedge clk) run_in <= 1'b1;
    mot(5'b00000);
    @(posedge clk) run_in <= 1'b0;
    wr(`PMIO_A_CTRL, 32'hA);
    @(posedge clk) run_in <= 1'b1;
    mot(5'b10011);
    @(posedge clk) jog_r <= 1'b1;
    mot(5'b10011);
    @(posedge clk) jog_r <= 1'b0;
    @(posedge clk) run_in <= 1'b0;
    mot(5'b00000);
    wr(`PMIO_A_CTRL, 32'h2);
    @(posedge clk) run_in <= 1'b1;
    mot(5'b01011);
    @(posedge clk) run_in <= 1'b0;
    mot(5'b00000);
    $display("test motion done");
  endtask
  // Full dwell strokes on the shear, switch-cut strokes on the press.
  task automatic t_cut();
    int wd, wb, wu;
    @(posedge clk);
    bot_fit <= 2'b10;
    top_fit <= 2'b10;
    wr(`PMIO_A_DDOWN, 32'h5);
    wr(`PMIO_A_DUP, 32'h3);
    wr(`PMIO_A_DBOOST, 32'h2);
    wr(`PMIO_A_CMD, 32'h1);
    fork
      pw(0, 20, wd);
      pw(4, 20, wb);
    join
    pw(2, 20, wu);
    `CHK(wd inside {[T*4:T*5+1]}, 1'b1)
    `CHK(wb inside {[T*1:T*2+1]}, 1'b1)
    `CHK(wu inside {[T*2:T*3+1]}, 1'b1)
    wr(`PMIO_A_DDOWN, 32'hA);
    wr(`PMIO_A_DUP, 32'hA);
    wr(`PMIO_A_CMD, 32'h2);
    fork
      pw(1, 20, wd);
      pw(5, 20, wb);
    join
    pw(3, 20, wu);
    `CHK(wd inside {[5:12]}, 1'b1)
    `CHK(wb inside {[T*1:T*2+1]}, 1'b1)
    `CHK(wu inside {[5:12]}, 1'b1)
    $display("test cut done");
  endtask
  // Manual stacker, then automatic stacking at the target count.
  task automatic t_stack();
    int w;
    logic [31:0] q;
    logic e;
    wr(`PMIO_A_DDOWN, 32'h1);
    wr(`PMIO_A_DUP, 32'h1);
    wr(`PMIO_A_DSTACK, 32'h3);
    wr(`PMIO_A_STARGET, 32'h2);
    @(posedge clk) man_st <= 1'b1;
    pw(7, 20, w);
    @(posedge clk) man_st <= 1'b0;
    `CHK(w inside {[T*2:T*3+1]}, 1'b1)
    apb(1'b0, `PMIO_A_STATUS, 32'h0, q, e);
    `CHK(q[31:16], 16'h0000)
    wr(`PMIO_A_CMD, 32'h1);
    pw(2, 30, w);
    apb(1'b0, `PMIO_A_STATUS, 32'h0, q, e);
    `CHK(q[31:16], 16'h0001)
    wr(`PMIO_A_CMD, 32'h1);
    pw(7, 60, w);
    `CHK(w inside {[T*2:T*3+1]}, 1'b1)
    $display("test stacker done");
  endtask
  // Item complete is refused out of run and pulses its dwell in run.
  task automatic t_item();
    int w;
    wr(`PMIO_A_DITEM, 32'h2);
    wr(`PMIO_A_CMD, 32'h4);
    pw(6, 30, w);
    `CHK(w, -1)
    @(posedge clk) run_in <= 1'b1;
    mot(5'b01011);
    wr(`PMIO_A_CMD, 32'h4);
    pw(6, 30, w);
    `CHK(w inside {[T:T*2+1]}, 1'b1)
    @(posedge clk) run_in <= 1'b0;
    $display("test item done");
  endtask
  // Print trigger pulse and message request, then hole reference capture.
  task automatic t_print_hole();
    int w;
    logic [31:0] q;
    logic e;
    wr(`PMIO_A_CTRL, 32'h30);
    @(posedge clk) print_det <= 1'b1;
    pw(8, 20, w);
    @(posedge clk) print_det <= 1'b0;
    `CHK(w inside {[T*9:T*10+1]}, 1'b1)
    apb(1'b0, `PMIO_A_STATUS, 32'h0, q, e);
    `CHK(q[8], 1'b1)
    wr(`PMIO_A_STATUS, 32'h100);
    apb(1'b0, `PMIO_A_STATUS, 32'h0, q, e);
    `CHK(q[8], 1'b0)
    @(posedge clk) mat_pos <= 32'h1234_5678;
    @(posedge clk) hole_det <= 1'b1;
    repeat (6) @(posedge clk);
    hole_det <= 1'b0;
    apb(1'b0, `PMIO_A_HOLEREF, 32'h0, q, e);
    `CHK(q, 32'h1234_5678)
    apb(1'b0, `PMIO_A_STATUS, 32'h0, q, e);
    `CHK(q[9], 1'b1)
    $display("test print and hole done");
  endtask
  // Reset, then the scenarios in turn.
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_motion();
    t_cut();
    t_stack();
    t_item();
    t_print_hole();
    end_sim();
  end
endmodule // press_motion_io_sequencer_tb_top
